// >>> ueh_regs.svh
/*
  register indices, field positions, masks and reset values of the endpoint
  handshake control block. assumes a word-aligned apb slave where the byte
  address is four times the register index.
*/
`ifndef UEH_REGS_SVH
`define UEH_REGS_SVH

// ----------------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------------
`define UEH_ADDR_W        16
`define UEH_IDX_W         14

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define UEH_IDX_CTL0      14'h1fa5
`define UEH_IDX_CTL1      14'h1fa4
`define UEH_IDX_CTL2      14'h1fa3
`define UEH_IDX_CTL3      14'h1fa2
`define UEH_IDX_FLG0      14'h1fdd
`define UEH_IDX_FLG1      14'h1fdc
`define UEH_IDX_FLG2      14'h1fdb
`define UEH_IDX_FLG3      14'h1fda
`define UEH_IDX_CFG       14'h1fa8

// ----------------------------------------------------------------------------
// control and acknowledge fields
// ----------------------------------------------------------------------------
`define UEH_BIT_DIR       7
`define UEH_BIT_DEND      6
`define UEH_BIT_STALL     5
`define UEH_BIT_TXRDY     4
`define UEH_CTL_MASK_EP0  8'hf0
`define UEH_CTL_MASK_DATA 8'h70

// ----------------------------------------------------------------------------
// service flag fields (ack bit n clears flag bit n)
// ----------------------------------------------------------------------------
`define UEH_FLG_STALL     3
`define UEH_FLG_SETUP     2
`define UEH_FLG_OUT       1
`define UEH_FLG_TXDONE    0
`define UEH_FLG_MASK_EP0  4'hf
`define UEH_FLG_MASK_DATA 4'hb
`define UEH_FLG_SETUP_VAL 4'h4

// ----------------------------------------------------------------------------
// configuration fields and reset values
// ----------------------------------------------------------------------------
`define UEH_CFG_ISO_LSB   0
`define UEH_CFG_IEN_LSB   4
`define UEH_RST_CTL       8'h00
`define UEH_RST_FLG       4'h0
`define UEH_RST_CFG       8'h00

`endif

// >>> ueh_pkg.sv
/*
  types of the endpoint handshake control block: token, event and response
  carriers toward the serial engine, and the control endpoint phase.
  assumes the serial engine runs on the same clock as the block.
*/
package ueh_pkg;

  typedef enum logic [1:0] {tok_setup, tok_in, tok_out} ueh_tok_kind_t;

  typedef enum logic [2:0] {
    ev_setup_rx, ev_out_rx, ev_in_acked, ev_in_sent, ev_stall_sent
  } ueh_evt_kind_t;

  typedef enum logic [2:0] {
    rsp_accept, rsp_data, rsp_status_zlp, rsp_nak, rsp_stall
  } ueh_rsp_code_t;

  typedef enum logic [1:0] {ctl_idle, ctl_data, ctl_status} ueh_phase_t;

  typedef struct packed {
    logic          valid;
    logic [1:0]    ep;
    ueh_tok_kind_t kind;
  } ueh_tok_t;

  typedef struct packed {
    logic          valid;
    logic [1:0]    ep;
    ueh_evt_kind_t kind;
  } ueh_evt_t;

  typedef struct packed {
    logic          valid;
    logic [1:0]    ep;
    ueh_rsp_code_t code;
  } ueh_rsp_t;

endpackage

// >>> ueh_ctrl.sv
/*
  endpoint handshake control: control endpoint zero and data endpoints one
  to three, with apb register access and token answers to the serial engine.
  assumes tokens and events come from logic on the same clock, one at a time.
*/
`timescale 1ns/1ps
`include "ueh_regs.svh"

module ueh_ctrl (
  input  wire logic                     clock,
  input  wire logic                     arst_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`UEH_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire ueh_pkg::ueh_tok_t        tok,
  input  wire ueh_pkg::ueh_evt_t        evt,
  output ueh_pkg::ueh_rsp_t             rsp,
  output logic      [3:0]               ep_irq
);
  import ueh_pkg::*;

  localparam logic [`UEH_IDX_W-1:0] CTL_IDX [4] = '{
    `UEH_IDX_CTL0, `UEH_IDX_CTL1, `UEH_IDX_CTL2, `UEH_IDX_CTL3};
  localparam logic [`UEH_IDX_W-1:0] FLG_IDX [4] = '{
    `UEH_IDX_FLG0, `UEH_IDX_FLG1, `UEH_IDX_FLG2, `UEH_IDX_FLG3};

  logic [`UEH_IDX_W-1:0] addr_idx;
  logic                  aligned;
  logic [3:0]            ctl_hit;
  logic [3:0]            flg_hit;
  logic                  cfg_hit;
  logic                  mapped;
  logic                  wr_en;
  logic [3:0]            ctl_wr;
  logic [7:0]            rd_data;
  logic [31:0]           prdata_reg;
  logic                  pslverr_reg;
  logic [7:0]            cfg_reg;
  logic [3:0][7:0]       ctl_q;
  logic [3:0][3:0]       flag_q;
  logic [3:0][3:0]       flag_nx;
  logic [3:0]            in_done;
  logic [3:0]            irq_reg;
  ueh_phase_t            phase_reg;
  ueh_phase_t            phase_next;
  ueh_rsp_t              rsp_reg;
  ueh_rsp_t              rsp_next;
  logic                  status_fin;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // --------------------------------------------------------------------------
  // apb slave: zero wait states, read data captured in the setup cycle
  // --------------------------------------------------------------------------
  assign addr_idx = paddr[`UEH_ADDR_W-1:2];
  assign aligned  = (paddr[1:0] == 2'h0);
  assign cfg_hit  = aligned && (addr_idx == `UEH_IDX_CFG);
  assign mapped   = (|ctl_hit) || (|flg_hit) || cfg_hit;
  assign wr_en    = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign prdata   = prdata_reg;
  assign pslverr  = pslverr_reg;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ctl_hit[i] = aligned && (addr_idx == CTL_IDX[i]);
      flg_hit[i] = aligned && (addr_idx == FLG_IDX[i]);
      ctl_wr[i]  = wr_en && ctl_hit[i];
    end
  end

  // ack bits are never stored, so they read back as zero
  always_comb begin
    rd_data = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (ctl_hit[i]) begin
        rd_data = ctl_q[i];
      end
      if (flg_hit[i]) begin
        rd_data = {4'h0, flag_q[i]};
      end
    end
    if (cfg_hit) begin
      rd_data = cfg_reg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel && !penable) begin
      prdata_reg  <= {24'h00_0000, rd_data};
      pslverr_reg <= !mapped;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= `UEH_RST_CFG;
    end else if (wr_en && cfg_hit) begin
      cfg_reg <= pwdata[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // control endpoint phase
  // --------------------------------------------------------------------------
  assign status_fin = (phase_reg == ctl_status) && evt.valid && (evt.ep == 2'd0) &&
                      (ctl_q[0][`UEH_BIT_DIR] ? (evt.kind == ev_out_rx)
                                              : (evt.kind == ev_in_acked));

  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      ctl_idle: begin
        phase_next = ctl_idle;
      end
      ctl_data: begin
        // last packet gone (or none queued): move to status
        if (ctl_q[0][`UEH_BIT_DEND] && !ctl_q[0][`UEH_BIT_TXRDY]) begin
          phase_next = ctl_status;
        end
      end
      ctl_status: begin
        if (status_fin) begin
          phase_next = ctl_idle;
        end
      end
    endcase
    if (evt.valid && (evt.ep == 2'd0) && (evt.kind == ev_setup_rx)) begin
      phase_next = ctl_data;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= ctl_idle;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // --------------------------------------------------------------------------
  // per-endpoint control bits, service flags and interrupt
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_ep
    localparam logic [7:0] CMASK = (g == 0) ? `UEH_CTL_MASK_EP0 : `UEH_CTL_MASK_DATA;
    localparam logic [3:0] FMASK = (g == 0) ? `UEH_FLG_MASK_EP0 : `UEH_FLG_MASK_DATA;
    logic [7:0] ctl_reg;
    logic [3:0] flag_reg;
    logic       hit;
    logic       iso;
    logic       set_setup;
    logic       set_out;
    logic       set_tx;
    logic       set_stall;

    assign hit       = evt.valid && (evt.ep == 2'(g));
    assign iso       = cfg_reg[`UEH_CFG_ISO_LSB + g];
    assign set_setup = (g == 0) && hit && (evt.kind == ev_setup_rx);
    assign set_out   = hit && (evt.kind == ev_out_rx);
    assign set_stall = hit && (evt.kind == ev_stall_sent);
    assign in_done[g] = hit && ((evt.kind == ev_in_acked) ||
                                (iso && (evt.kind == ev_in_sent)));
    // endpoint zero also completes on the OUT status of a control read
    assign set_tx    = in_done[g] || ((g == 0) && status_fin);
    assign ctl_q[g]  = ctl_reg;
    assign flag_q[g] = flag_reg;

    // a software write wins over the hardware clear of transmit-ready
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        ctl_reg <= `UEH_RST_CTL;
      end else if (ctl_wr[g]) begin
        ctl_reg <= pwdata[7:0] & CMASK;
      end else if (in_done[g]) begin
        ctl_reg[`UEH_BIT_TXRDY] <= 1'b0;
      end
    end

    // clears first, then sets, so a same-cycle event is kept
    always_comb begin
      flag_nx[g] = flag_reg;
      if (ctl_wr[g]) begin
        flag_nx[g] = flag_nx[g] & ~(pwdata[3:0] & FMASK);
      end
      if (set_setup) begin
        flag_nx[g] = `UEH_FLG_SETUP_VAL;
      end else begin
        if (set_out) begin
          flag_nx[g][`UEH_FLG_OUT] = 1'b1;
        end
        if (set_tx) begin
          flag_nx[g][`UEH_FLG_TXDONE] = 1'b1;
        end
        if (set_stall) begin
          flag_nx[g][`UEH_FLG_STALL] = 1'b1;
        end
      end
    end

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        flag_reg <= `UEH_RST_FLG;
      end else begin
        flag_reg <= flag_nx[g];
      end
    end

    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        irq_reg[g] <= 1'b0;
      end else begin
        irq_reg[g] <= cfg_reg[`UEH_CFG_IEN_LSB + g] && (|flag_nx[g]);
      end
    end
  end

  assign ep_irq = irq_reg;

  // --------------------------------------------------------------------------
  // token answers, one cycle after the token
  // --------------------------------------------------------------------------
  always_comb begin
    logic [7:0] c;
    logic [3:0] f;
    c = ctl_q[tok.ep];
    f = flag_q[tok.ep];
    rsp_next.valid = tok.valid;
    rsp_next.ep    = tok.ep;
    rsp_next.code  = rsp_nak;
    unique case (tok.kind)
      tok_setup: begin
        // an early setup is always taken on endpoint zero
        rsp_next.code = (tok.ep == 2'd0) ? rsp_accept : rsp_stall;
      end
      tok_in: begin
        if (c[`UEH_BIT_STALL]) begin
          rsp_next.code = rsp_stall;
        end else if (c[`UEH_BIT_TXRDY]) begin
          rsp_next.code = rsp_data;
        end else if ((tok.ep == 2'd0) && (phase_reg == ctl_status) &&
                     c[`UEH_BIT_DEND] && !c[`UEH_BIT_DIR]) begin
          rsp_next.code = rsp_status_zlp;
        end
      end
      tok_out: begin
        if (c[`UEH_BIT_STALL]) begin
          rsp_next.code = rsp_stall;
        end else if (f[`UEH_FLG_OUT] || ((tok.ep == 2'd0) && f[`UEH_FLG_SETUP])) begin
          rsp_next.code = rsp_nak;
        end else begin
          rsp_next.code = rsp_accept;
        end
      end
      default: begin
        rsp_next.code = rsp_nak;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rsp_reg <= '{valid: 1'b0, ep: 2'd0, code: rsp_nak};
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp = rsp_reg;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_stall_token_answer: assert property (
    tok.valid && (tok.kind != tok_setup) && ctl_q[tok.ep][`UEH_BIT_STALL]
    |=> rsp.valid && (rsp.code == rsp_stall))
    else $error("halted endpoint did not stall");

  a_out_pending_nak: assert property (
    tok.valid && (tok.kind == tok_out) && flag_q[tok.ep][`UEH_FLG_OUT] &&
    !ctl_q[tok.ep][`UEH_BIT_STALL] |=> rsp.code == rsp_nak)
    else $error("OUT accepted while data pending");

  a_setup_clears_flags: assert property (
    evt.valid && (evt.ep == 2'd0) && (evt.kind == ev_setup_rx)
    |=> (flag_q[0] == 4'h4) && (phase_reg == ctl_data))
    else $error("setup did not reset endpoint zero flags");

  a_txrdy_ack_clear: assert property (
    evt.valid && (evt.kind == ev_in_acked) && !ctl_wr[evt.ep]
    |=> !ctl_q[$past(evt.ep)][`UEH_BIT_TXRDY])
    else $error("transmit-ready not cleared by ACK");

  a_iso_sent_clear: assert property (
    evt.valid && (evt.kind == ev_in_sent) && cfg_reg[evt.ep] && !ctl_wr[evt.ep]
    |=> !ctl_q[$past(evt.ep)][`UEH_BIT_TXRDY] && flag_q[$past(evt.ep)][0])
    else $error("isochronous send did not clear transmit-ready");

  a_ack_clears_flag: assert property (
    ctl_wr[1] && pwdata[`UEH_FLG_TXDONE] && !(evt.valid && (evt.ep == 2'd1))
    |=> !flag_q[1][`UEH_FLG_TXDONE] && (ctl_q[1][3:0] == 4'h0))
    else $error("ack write did not clear transmit-done");

  a_set_beats_clear: assert property (
    evt.valid && (evt.kind == ev_out_rx) && ctl_wr[evt.ep] && pwdata[`UEH_FLG_OUT]
    |=> flag_q[$past(evt.ep)][`UEH_FLG_OUT])
    else $error("received packet lost to a same-cycle ack");

  a_status_zlp_in: assert property (
    tok.valid && (tok.kind == tok_in) && (tok.ep == 2'd0) && (phase_reg == ctl_status) &&
    !ctl_q[0][7] && (ctl_q[0][6:4] == 3'b100) |=> rsp.code == rsp_status_zlp)
    else $error("status IN not answered with DATA1");

  a_status_done_keep: assert property (
    status_fin && !ctl_wr[0] && cfg_reg[4]
    |=> (phase_reg == ctl_idle) && ctl_q[0][`UEH_BIT_DEND] && flag_q[0][0] && ep_irq[0])
    else $error("status completion mishandled");

  a_out_flag_irq: assert property (
    flag_nx[1][`UEH_FLG_OUT] && cfg_reg[5] |=> ep_irq[1])
    else $error("out-received did not interrupt");

  a_reserved_zero: assert property (
    psel && !penable && (flg_hit[1] || flg_hit[2] || flg_hit[3] || ctl_hit[2])
    |=> (prdata[31:8] == 24'h0) && !prdata[2] && !prdata[7])
    else $error("reserved bit read nonzero");

  // a setup on endpoint zero is taken even while older data is pending
  a_setup_ep0_taken: assert property (
    tok.valid && (tok.kind == tok_setup) && (tok.ep == 2'd0)
    |=> rsp.valid && (rsp.code == rsp_accept))
    else $error("setup on endpoint zero not taken");

  c_setup_seen:    cover property (evt.valid && (evt.kind == ev_setup_rx) ##1 rsp.valid);
  c_status_done:   cover property (phase_reg == ctl_status ##1 phase_reg == ctl_idle);
  c_stall_sent:    cover property (rsp.valid && (rsp.code == rsp_stall));
  c_iso_clear:     cover property (evt.valid && (evt.kind == ev_in_sent) && cfg_reg[evt.ep]);
  c_out_nak:       cover property (rsp.valid && (rsp.code == rsp_nak));

endmodule

// >>> ueh_host_model.sv
/*
  host side model for the endpoint handshake block: issues tokens and, from
  each answer other than NAK, the handshake event that the serial engine would report.
  assumes the block answers a token one cycle after taking it, same clock.
*/
`timescale 1ns/1ps
module ueh_host_model (
  input  wire logic              clock,
  input  wire ueh_pkg::ueh_rsp_t rsp,
  output ueh_pkg::ueh_tok_t      tok,
  output ueh_pkg::ueh_evt_t      evt
);
  import ueh_pkg::*;

  int gap;

  initial begin
    tok = '0;
    evt = '0;
    gap = 0;
  end

  // --------------------------------------------------------------------------
  // one transaction: token, answer, then handshake event after gap cycles
  // --------------------------------------------------------------------------
  task automatic xfer(input logic [1:0] ep, input ueh_tok_kind_t k, input bit sent_only,
                      output ueh_rsp_t r);
    ueh_evt_kind_t ev;
    bit            fire;
    @(posedge clock);
    tok <= '{valid: 1'b1, ep: ep, kind: k};
    @(posedge clock);
    tok <= '{valid: 1'b0, ep: ~ep, kind: k};
    @(posedge clock);
    r = rsp;
    ev = ev_out_rx;
    fire = 1'b1;
    case (r.code)
      rsp_accept: ev = (k == tok_setup) ? ev_setup_rx : ev_out_rx;
      rsp_data: ev = sent_only ? ev_in_sent : ev_in_acked;
      rsp_status_zlp: ev = ev_in_acked;
      rsp_stall: ev = ev_stall_sent;
      default: fire = 1'b0;
    endcase
    if (fire) begin
      repeat (gap) @(posedge clock);
      evt <= '{valid: 1'b1, ep: ep, kind: ev};
      @(posedge clock);
      evt <= '{valid: 1'b0, ep: ~ep, kind: ev};
    end
  endtask
endmodule

// >>> usb_endpoint_handshake_ctrl_test.sv
/*
  self-checking bench of the endpoint handshake block: apb register tasks,
  host token transactions and expected flag, control and answer values.
  assumes the host model and the block share one 20 MHz clock.
*/
`timescale 1ns/1ps
`include "ueh_regs.svh"
module usb_endpoint_handshake_ctrl_test;
  import ueh_pkg::*;

  logic        clock;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  ueh_tok_t    tok;
  ueh_evt_t    evt;
  ueh_rsp_t    rsp;
  logic [3:0]  ep_irq;
  int          n_fail;
  int          checks_done;
  logic [13:0] ci [4];
  logic [13:0] fi [4];
  logic [31:0] d;
  logic        e;

  ueh_ctrl dut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tok(tok), .evt(evt), .rsp(rsp), .ep_irq(ep_irq));

  ueh_host_model host (.clock(clock), .rsp(rsp), .tok(tok), .evt(evt));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // --------------------------------------------------------------------------
  // bus and compare tasks
  // --------------------------------------------------------------------------
  task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] wd,
                     output logic [31:0] rdat, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_rsp(input ueh_rsp_t exp, input ueh_rsp_t got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error rsp expected %h seen %h", exp, got);
    end
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] v);
    logic [31:0] x;
    logic        y;
    apb(1'b1, idx, v, x, y);
  endtask

  task automatic rdc(input logic [13:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, d, e);
    chk($sformatf("reg %h", idx), {24'h000000, exp}, d);
  endtask

  task automatic irq(input logic [3:0] exp);
    chk("ep_irq", {28'h0000000, exp}, {28'h0000000, ep_irq});
  endtask

  task automatic tx(input int ep, input ueh_tok_kind_t k, input bit so,
                    input ueh_rsp_code_t exp);
    ueh_rsp_t r;
    host.xfer(2'(ep), k, so, r);
    chk_rsp('{valid: 1'b1, ep: 2'(ep), code: exp}, r);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("Error watchdog expected end seen timeout");
    wrap_up();
  end

  // --------------------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    n_fail = 0;
    checks_done = 0;
    ci = '{`UEH_IDX_CTL0, `UEH_IDX_CTL1, `UEH_IDX_CTL2, `UEH_IDX_CTL3};
    fi = '{`UEH_IDX_FLG0, `UEH_IDX_FLG1, `UEH_IDX_FLG2, `UEH_IDX_FLG3};
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdc(ci[i], 8'h00);
      rdc(fi[i], 8'h00);
    end
    rdc(`UEH_IDX_CFG, 8'h00);
    irq(4'h0);
    $display("test reset done");

    wr(ci[1], 8'hff);
    rdc(ci[1], 8'h70);
    wr(ci[0], 8'hff);
    rdc(ci[0], 8'hf0);
    wr(fi[1], 8'hff);
    rdc(fi[1], 8'h00);
    wr(ci[0], 8'h00);
    wr(ci[1], 8'h00);
    apb(1'b0, 14'h0001, 8'h00, d, e);
    chk("pslverr", 32'h00000001, {31'h00000000, e});
    $display("test reserved done");

    wr(`UEH_IDX_CFG, 8'hf8);
    host.gap = 2;
    for (int ep = 1; ep < 4; ep++) begin
      tx(ep, tok_out, 1'b0, rsp_accept);
      rdc(fi[ep], 8'h02);
      irq(4'h1 << ep);
      tx(ep, tok_out, 1'b0, rsp_nak);
      wr(ci[ep], 8'h02);
      rdc(fi[ep], 8'h00);
      tx(ep, tok_in, 1'b0, rsp_nak);
      wr(ci[ep], 8'h10);
      tx(ep, tok_in, 1'b1, rsp_data);
      rdc(ci[ep], (ep == 3) ? 8'h00 : 8'h10);
      if (ep != 3) begin
        tx(ep, tok_in, 1'b0, rsp_data);
        rdc(ci[ep], 8'h00);
      end
      rdc(fi[ep], 8'h01);
      irq(4'h1 << ep);
      wr(ci[ep], 8'h01);
      rdc(fi[ep], 8'h00);
    end
    $display("test data endpoints done");

    wr(ci[2], 8'h20);
    tx(2, tok_in, 1'b0, rsp_stall);
    rdc(fi[2], 8'h08);
    tx(2, tok_out, 1'b0, rsp_stall);
    wr(ci[2], 8'h08);
    rdc(fi[2], 8'h00);
    tx(2, tok_in, 1'b0, rsp_nak);
    tx(1, tok_setup, 1'b0, rsp_stall);
    rdc(fi[1], 8'h08);
    wr(ci[1], 8'h08);
    rdc(fi[1], 8'h00);
    $display("test stall done");

    host.gap = 0;
    wr(ci[0], 8'h20);
    tx(0, tok_in, 1'b0, rsp_stall);
    wr(ci[0], 8'h00);
    tx(0, tok_setup, 1'b0, rsp_accept);
    rdc(fi[0], 8'h04);
    tx(0, tok_out, 1'b0, rsp_nak);
    irq(4'h1);
    wr(`UEH_IDX_CFG, 8'h08);
    rdc(`UEH_IDX_CFG, 8'h08);
    irq(4'h0);
    wr(`UEH_IDX_CFG, 8'hf8);
    wr(ci[0], 8'h84);
    rdc(fi[0], 8'h00);
    wr(ci[0], 8'hd0);
    tx(0, tok_in, 1'b0, rsp_data);
    rdc(ci[0], 8'hc0);
    rdc(fi[0], 8'h01);
    wr(ci[0], 8'hc1);
    tx(0, tok_out, 1'b0, rsp_accept);
    rdc(fi[0], 8'h03);
    rdc(ci[0], 8'hc0);
    irq(4'h1);
    wr(ci[0], 8'h03);
    rdc(fi[0], 8'h00);
    $display("test control read done");

    tx(0, tok_setup, 1'b0, rsp_accept);
    wr(ci[0], 8'h44);
    tx(0, tok_in, 1'b0, rsp_status_zlp);
    rdc(fi[0], 8'h01);
    wr(ci[0], 8'h01);
    tx(0, tok_setup, 1'b0, rsp_accept);
    wr(ci[0], 8'h64);
    tx(0, tok_in, 1'b0, rsp_stall);
    rdc(fi[0], 8'h08);
    wr(ci[0], 8'h08);
    rdc(fi[0], 8'h00);
    $display("test control no data done");
    wrap_up();
  end
endmodule
